// >>> logic/rsb_defines.vh
// Register offsets, field positions and timing counts for the status bank.
`ifndef RSB_DEFINES_VH
`define RSB_DEFINES_VH
`define RSB_OFF_PAGE_SEL 8'h29
`define RSB_OFF_GAIN_STAT 8'h2A
`define RSB_OFF_STRENGTH 8'h2B
`define RSB_OFF_GAIN_LEVEL 8'h2C
`define RSB_OFF_ADC_DISP 8'h2D
`define RSB_PAGE_SEL_RESET 8'h00
`define RSB_ADC_PAGE_HI 7
`define RSB_ADC_PAGE_LO 6
`define RSB_GL_PAGE_HI 5
`define RSB_GL_PAGE_LO 4
`define RSB_SS_PAGE_HI 3
`define RSB_SS_PAGE_LO 0
`define RSB_SS_REALTIME 4'h0
`define RSB_SS_NOISE 4'h2
`define RSB_SS_PILOT 4'h4
`define RSB_SS_SECOND 4'h6
`define RSB_SS_PEAK 4'h8
`define RSB_SS_COLL_TIME 4'hC
`define RSB_SS_COLL_DUR 4'hD
`define RSB_SS_ERR_TIME 4'hE
`define RSB_ADC_SETTLE_NS 20000
`define RSB_CLK_NS 50
`define RSB_ADC_SETTLE_CYC ((`RSB_ADC_SETTLE_NS + `RSB_CLK_NS - 1) / `RSB_CLK_NS)
`endif

// >>> logic/rsb_adc_capture.v
// ADC result holding register with conversion settle timer.
`timescale 1ns/1ns
`include "rsb_defines.vh"
module rsb_adc_capture #(
  parameter CNT_W = 10,
  parameter SETTLE_CYC = `RSB_ADC_SETTLE_CYC
) (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Conversion control
  input wire adc_trigger,
  input wire [7:0] adc_sample,
  // Result
  output reg [7:0] adc_result_r,
  output reg adc_valid_r
);
  reg [CNT_W-1:0] cnt_r;
  reg busy_r;

  // -----------------------------------------------------------------
  // Settle timer
  // -----------------------------------------------------------------
  // result after settle time.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= {CNT_W{1'b0}};
      busy_r <= 1'b0;
      adc_result_r <= 8'h00;
      adc_valid_r <= 1'b0;
    end else if (adc_trigger) begin
      // A retrigger restarts the wait; the old result stays visible.
      cnt_r <= SETTLE_CYC[CNT_W-1:0] - {{(CNT_W-1){1'b0}}, 1'b1};
      busy_r <= 1'b1;
      adc_valid_r <= 1'b0;
    end else if (busy_r) begin
      if (cnt_r == {CNT_W{1'b0}}) begin
        busy_r <= 1'b0;
        adc_result_r <= adc_sample;
        adc_valid_r <= 1'b1;
      end else begin
        cnt_r <= cnt_r - {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule

// >>> logic/rsb_status_bank.v
// Reader status register bank with Avalon-MM slave access.
// What this block does
// - Page selector fields choose 2Dh, 2Ch pages
// - Strength page code selects shown value type
// - Noise values captured on store command
// - Status bit 7 reports sub-carrier phase
// - Status bits 6:4 report gain step
// - Bit 3 decode channel, held during reception
// - Bits 2:0 carrier, PLL, oscillator ready
// - Strength display: Q high nibble, I low
// - Gain page 00: Q bits 5:3, I 2:0
// - Gain page 00 bits 7:6 read zero
// - ADC result valid 20 us after trigger
//
// Implementation choice: the Avalon-MM register port.
`timescale 1ns/1ns
`include "rsb_defines.vh"
module rsb_status_bank #(
  parameter ADDR_W = 8,
  parameter ADC_CNT_W = 10
) (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Avalon-MM slave
  input wire [ADDR_W-1:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  output reg [1:0] avs_response,
  // Receiver status inputs
  input wire subc_in_phase,
  input wire [2:0] gain_step,
  input wire q_decode_sel,
  input wire rx_start,
  input wire tx_start,
  input wire carrier_stable_flag,
  input wire pll_locked,
  input wire osc_stable,
  // Signal strength sources
  input wire [3:0] rt_q_level,
  input wire [3:0] rt_i_level,
  input wire [3:0] pilot_q_level,
  input wire [3:0] pilot_i_level,
  input wire [3:0] second_q_level,
  input wire [3:0] second_i_level,
  input wire [3:0] peak_q_level,
  input wire [3:0] peak_i_level,
  input wire [7:0] collision_exceed_time,
  input wire [7:0] collision_exceed_duration,
  input wire [7:0] violation_bit_time,
  input wire store_strength_cmd,
  // Gain level and page sources
  input wire [2:0] gain_level_q,
  input wire [2:0] gain_level_i,
  input wire [7:0] gain_level_page1,
  input wire [7:0] gain_level_page2,
  input wire [7:0] gain_level_page3,
  input wire [7:0] adc_page1,
  input wire [7:0] adc_page2,
  input wire [7:0] adc_page3,
  // ADC conversion
  input wire adc_trigger_cmd,
  input wire [7:0] adc_sample,
  // Status outputs
  output reg adc_valid,
  output reg [7:0] page_select
);
  reg [7:0] page_sel_r;
  reg [7:0] noise_level_r;
  reg decode_q_r;
  reg req_done_r;
  reg [31:0] rdata_nxt;
  reg hit_nxt;
  reg [7:0] page_sel_nxt;
  reg req_done_nxt;
  reg waitreq_nxt;
  reg [31:0] rdata_out_nxt;
  reg [1:0] resp_nxt;
  reg [7:0] noise_level_nxt;
  reg decode_q_nxt;
  wire [7:0] adc_result;
  wire adc_valid_w;
  wire [1:0] adc_display_page;
  wire [1:0] gain_level_display_page;
  wire [3:0] strength_display_page;
  wire [7:0] addr8;
  wire req;
  wire sel_write;
  wire [7:0] gain_level_byte;
  wire [7:0] adc_byte;

  // Response codes of the bus; decode error flags an unmapped offset.
  localparam [1:0] RESP_OKAY = 2'h0;
  localparam [1:0] RESP_DECODE = 2'h3;

  // -----------------------------------------------------------------
  // Page fields
  // -----------------------------------------------------------------
  // page field split.
  assign adc_display_page =
    page_sel_r[`RSB_ADC_PAGE_HI:`RSB_ADC_PAGE_LO];
  assign gain_level_display_page =
    page_sel_r[`RSB_GL_PAGE_HI:`RSB_GL_PAGE_LO];
  assign strength_display_page =
    page_sel_r[`RSB_SS_PAGE_HI:`RSB_SS_PAGE_LO];
  assign addr8 = avs_address[7:0];
  assign req = (avs_read | avs_write) & ~req_done_r;
  // Only byte lane 0 carries a writable field.
  assign sel_write = avs_write & avs_byteenable[0] &
    (addr8 == `RSB_OFF_PAGE_SEL);

  // -----------------------------------------------------------------
  // ADC result holder
  // -----------------------------------------------------------------
  rsb_adc_capture #(
    .CNT_W(ADC_CNT_W),
    .SETTLE_CYC(`RSB_ADC_SETTLE_CYC)
  ) u_adc (
    .clk(clk),
    .rst_b(rst_b),
    .adc_trigger(adc_trigger_cmd),
    .adc_sample(adc_sample),
    .adc_result_r(adc_result),
    .adc_valid_r(adc_valid_w)
  );

  // -----------------------------------------------------------------
  // Strength page mux
  // -----------------------------------------------------------------
  function [7:0] pick_strength;
    input [3:0] sel;
    input [7:0] rt;
    input [7:0] noise;
    input [7:0] pilot;
    input [7:0] second;
    input [7:0] peak;
    input [7:0] ctime;
    input [7:0] cdur;
    input [7:0] etime;
    begin
      case (sel)
        `RSB_SS_REALTIME: pick_strength = rt;
        `RSB_SS_NOISE: pick_strength = noise;
        `RSB_SS_PILOT: pick_strength = pilot;
        `RSB_SS_SECOND: pick_strength = second;
        `RSB_SS_PEAK: pick_strength = peak;
        `RSB_SS_COLL_TIME: pick_strength = ctime;
        `RSB_SS_COLL_DUR: pick_strength = cdur;
        `RSB_SS_ERR_TIME: pick_strength = etime;
        default: pick_strength = 8'h00;
      endcase
    end
  endfunction

  // -----------------------------------------------------------------
  // Paged display mux
  // -----------------------------------------------------------------
  // Pages 1 to 3 pass straight through; their layout is set upstream.
  function [7:0] pick_page;
    input [1:0] sel;
    input [7:0] page0;
    input [7:0] page1;
    input [7:0] page2;
    input [7:0] page3;
    begin
      case (sel)
        2'h0: pick_page = page0;
        2'h1: pick_page = page1;
        2'h2: pick_page = page2;
        default: pick_page = page3;
      endcase
    end
  endfunction

  assign gain_level_byte = pick_page(gain_level_display_page,
    {2'h0, gain_level_q, gain_level_i}, gain_level_page1,
    gain_level_page2, gain_level_page3);
  assign adc_byte = pick_page(adc_display_page, adc_result, adc_page1,
    adc_page2, adc_page3);

  // -----------------------------------------------------------------
  // Captured state
  // -----------------------------------------------------------------
  always @* begin
    noise_level_nxt = noise_level_r;
    decode_q_nxt = decode_q_r;
    if (store_strength_cmd) begin
      noise_level_nxt = {rt_q_level, rt_i_level};
    end
    // hold decode channel.
    // A reception start wins over a transmission start in one cycle.
    if (rx_start) begin
      decode_q_nxt = q_decode_sel;
    end else if (tx_start) begin
      decode_q_nxt = 1'b0;
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      noise_level_r <= 8'h00;
      decode_q_r <= 1'b0;
    end else begin
      noise_level_r <= noise_level_nxt;
      decode_q_r <= decode_q_nxt;
    end
  end

  // -----------------------------------------------------------------
  // Read decode
  // -----------------------------------------------------------------
  // reads are side-effect free.
  always @* begin
    rdata_nxt = 32'h0000_0000;
    hit_nxt = 1'b1;
    case (addr8)
      `RSB_OFF_PAGE_SEL: rdata_nxt[7:0] = page_sel_r;
      `RSB_OFF_GAIN_STAT: begin
        rdata_nxt[7] = subc_in_phase;
        rdata_nxt[6:4] = gain_step;
        rdata_nxt[3] = decode_q_r;
        rdata_nxt[2:0] = {carrier_stable_flag, pll_locked, osc_stable};
      end
      `RSB_OFF_STRENGTH: begin
        rdata_nxt[7:0] = pick_strength(strength_display_page,
          {rt_q_level, rt_i_level}, noise_level_r,
          {pilot_q_level, pilot_i_level},
          {second_q_level, second_i_level},
          {peak_q_level, peak_i_level}, collision_exceed_time,
          collision_exceed_duration, violation_bit_time);
      end
      `RSB_OFF_GAIN_LEVEL: begin
        rdata_nxt[7:0] = gain_level_byte;
      end
      `RSB_OFF_ADC_DISP: begin
        rdata_nxt[7:0] = adc_byte;
      end
      default: hit_nxt = 1'b0;
    endcase
  end

  // -----------------------------------------------------------------
  // Bus slave
  // -----------------------------------------------------------------
  // Every access costs one wait cycle so read data can be registered.
  always @* begin
    // Read data and response hold between accesses.
    page_sel_nxt = page_sel_r;
    req_done_nxt = 1'b0;
    waitreq_nxt = 1'b1;
    rdata_out_nxt = avs_readdata;
    resp_nxt = avs_response;
    if (req) begin
      req_done_nxt = 1'b1;
      waitreq_nxt = 1'b0;
      resp_nxt = hit_nxt ? RESP_OKAY : RESP_DECODE;
      rdata_out_nxt = avs_read ? rdata_nxt : 32'h0000_0000;
      if (sel_write) begin
        page_sel_nxt = avs_writedata[7:0];
      end
    end
  end

  // -----------------------------------------------------------------
  // Bus slave registers
  // -----------------------------------------------------------------
  // The selector copy lags one edge so the port stays a plain flop.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      page_sel_r <= `RSB_PAGE_SEL_RESET;
      req_done_r <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
      avs_response <= RESP_OKAY;
      adc_valid <= 1'b0;
      page_select <= `RSB_PAGE_SEL_RESET;
    end else begin
      page_sel_r <= page_sel_nxt;
      req_done_r <= req_done_nxt;
      avs_waitrequest <= waitreq_nxt;
      avs_readdata <= rdata_out_nxt;
      avs_response <= resp_nxt;
      adc_valid <= adc_valid_w;
      page_select <= page_sel_r;
    end
  end
endmodule

// >>> testbench/rsb_status_checker.sv
// Checker for the reader status register bank.
`timescale 1ns/1ns
module rsb_status_checker #(parameter ADDR_W = 8) (
  // Bus
  input wire clk, rst_b, avs_read, avs_write, avs_waitrequest,
  input wire [ADDR_W-1:0] avs_address,
  input wire [31:0] avs_writedata, avs_readdata,
  input wire [3:0] avs_byteenable,
  // Status
  input wire subc_in_phase, carrier_stable_flag, pll_locked, osc_stable,
  input wire [2:0] gain_step, gain_level_q, gain_level_i,
  input wire [3:0] rt_q_level, rt_i_level,
  input wire [7:0] page_select,
  input wire adc_trigger_cmd, adc_valid
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire rd = avs_read && !avs_waitrequest;
  wire wr = avs_write && !avs_waitrequest;
  wire [7:0] q = avs_readdata[7:0];
  logic [9:0] cnt_r;
  // Saturates so a stale count never wraps into the legal window.
  always @(posedge clk or negedge rst_b)
    if (!rst_b) cnt_r <= 10'h0;
    else if (adc_trigger_cmd) cnt_r <= 10'h0;
    else if (cnt_r != 10'h3FF) cnt_r <= cnt_r + 10'h1;
  a_phase_bit: assert property (rd && avs_address == 8'h2A
    |-> q[7] == subc_in_phase) else $error("phase bit wrong");
  a_gain_step: assert property (rd && avs_address == 8'h2A
    |-> q[6:4] == gain_step) else $error("gain step wrong");
  a_ready_flags: assert property (rd && avs_address == 8'h2A
    |-> q[2:0] == {carrier_stable_flag, pll_locked, osc_stable})
    else $error("ready flags wrong");
  a_strength_live: assert property (rd && avs_address == 8'h2B
    && page_select[3:0] == 4'h0 |-> q == {rt_q_level, rt_i_level})
    else $error("live strength wrong");
  a_gain_page0: assert property (rd && avs_address == 8'h2C
    && page_select[5:4] == 2'h0 |-> q == {2'h0, gain_level_q, gain_level_i})
    else $error("gain page wrong");
  a_page_write: assert property (wr && avs_address == 8'h29
    && avs_byteenable[0] |=> page_select == $past(avs_writedata[7:0]))
    else $error("page write lost");
  a_ro_ignored: assert property (wr && avs_address != 8'h29
    |=> $stable(page_select) [*2]) else $error("read-only write seen");
  a_be_masked: assert property (wr && avs_address == 8'h29
    && !avs_byteenable[0] |=> $stable(page_select) [*2])
    else $error("masked write seen");
  a_adc_settle: assert property ($rose(adc_valid)
    |-> cnt_r >= 10'd399 && cnt_r <= 10'd402) else $error("adc timing");
  c_adc: cover property ($rose(adc_valid));
  c_wr: cover property (wr && avs_address == 8'h29);
  c_coll: cover property (rd && page_select[3:0] == 4'hC);
endmodule
bind rsb_status_bank rsb_status_checker #(.ADDR_W(ADDR_W)) i_rsb_status_checker
  (.clk, .rst_b, .avs_read, .avs_write, .avs_waitrequest, .avs_address,
  .avs_writedata, .avs_readdata, .avs_byteenable, .subc_in_phase,
  .carrier_stable_flag, .pll_locked, .osc_stable, .gain_step, .gain_level_q,
  .gain_level_i, .rt_q_level, .rt_i_level, .page_select, .adc_trigger_cmd,
  .adc_valid);

// >>> testbench/rsb_status_bank_tb_top.sv
// Testbench for the reader status register bank.
`timescale 1ns/1ns
module rsb_status_bank_tb_top;
  logic clk = 0, rst_b = 0, avs_read = 0, avs_write = 0, avs_waitrequest;
  logic [7:0] avs_address = 8'h0, page_select, q, adc_sample = 8'h5A;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic [3:0] avs_byteenable = 4'hF;
  logic [1:0] avs_response, rsp;
  logic subc_in_phase = 0, q_decode_sel = 0, rx_start = 0, tx_start = 0;
  logic carrier_stable_flag = 0, pll_locked = 0, osc_stable = 0, adc_valid;
  logic store_strength_cmd = 0, adc_trigger_cmd = 0;
  logic [2:0] gain_step = 0, gain_level_q = 3'h4, gain_level_i = 3'h3;
  logic [3:0] rt_q_level = 4'hA, rt_i_level = 4'h5, pilot_q_level = 4'h1;
  logic [3:0] pilot_i_level = 4'h2, second_q_level = 4'h3;
  logic [3:0] second_i_level = 4'h4, peak_q_level = 4'h6, peak_i_level = 4'h7;
  logic [7:0] collision_exceed_time = 8'h81, collision_exceed_duration = 8'h92;
  logic [7:0] violation_bit_time = 8'hA3, gain_level_page1 = 8'h11;
  logic [7:0] gain_level_page2 = 8'h22, gain_level_page3 = 8'h33;
  logic [7:0] adc_page1 = 8'h44, adc_page2 = 8'h55, adc_page3 = 8'h66;
  int failures = 0, total_checks = 0, cyc = 0, n;
  always #25 clk = ~clk;
  rsb_status_bank i_rsb_status_bank (.clk, .rst_b, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .avs_response, .subc_in_phase, .gain_step,
    .q_decode_sel, .rx_start, .tx_start, .carrier_stable_flag, .pll_locked,
    .osc_stable, .rt_q_level, .rt_i_level, .pilot_q_level, .pilot_i_level,
    .second_q_level, .second_i_level, .peak_q_level, .peak_i_level,
    .collision_exceed_time, .collision_exceed_duration, .violation_bit_time,
    .store_strength_cmd, .gain_level_q, .gain_level_i, .gain_level_page1,
    .gain_level_page2, .gain_level_page3, .adc_page1, .adc_page2, .adc_page3,
    .adc_trigger_cmd, .adc_sample, .adc_valid, .page_select);
  task give_verdict;
    if (failures == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [7:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      $display("BAD %0t got %h exp %h", $time, got, exp);
      failures++;
    end
  endtask
  // One bus access; held until waitrequest is sampled low.
  task acc(input logic w, input logic [7:0] a, d);
    @(posedge clk);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata[7:0];
    rsp = avs_response;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task rd(input logic [7:0] a, e);
    acc(0, a, 8'h0);
    chk(q, e);
  endtask
  function logic [7:0] ss_exp(input logic [3:0] c);
    case (c)
      4'h0: ss_exp = {rt_q_level, rt_i_level};
      4'h2: ss_exp = 8'hA5;
      4'h4: ss_exp = {pilot_q_level, pilot_i_level};
      4'h6: ss_exp = {second_q_level, second_i_level};
      4'h8: ss_exp = {peak_q_level, peak_i_level};
      4'hC: ss_exp = collision_exceed_time;
      4'hD: ss_exp = collision_exceed_duration;
      4'hE: ss_exp = violation_bit_time;
      default: ss_exp = 8'h00;
    endcase
  endfunction
  // A hang is cut short well above the expected run length.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      give_verdict;
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    rd(8'h29, 8'h00);
    {subc_in_phase, gain_step, q_decode_sel} <= 5'h1B;
    {carrier_stable_flag, osc_stable, rx_start} <= 3'h7;
    @(posedge clk);
    {rx_start, q_decode_sel} <= 2'h0;
    rd(8'h2A, 8'hDD);
    {subc_in_phase, gain_step, tx_start} <= 5'h05;
    {carrier_stable_flag, pll_locked, osc_stable} <= 3'h2;
    @(posedge clk);
    tx_start <= 1'b0;
    rd(8'h2A, 8'h22);
    store_strength_cmd <= 1'b1;
    @(posedge clk);
    {store_strength_cmd, rt_q_level, rt_i_level} <= 9'h03C;
    for (n = 0; n < 16; n++) begin
      acc(1, 8'h29, n[7:0]);
      rd(8'h2B, ss_exp(n[3:0]));
    end
    for (n = 0; n < 4; n++) begin
      acc(1, 8'h29, {n[1:0], n[1:0], 4'h0});
      rd(8'h2C, n == 1 ? 8'h11 : n == 2 ? 8'h22 : n == 3 ? 8'h33 : 8'h23);
      if (n > 0) rd(8'h2D, n == 1 ? 8'h44 : n == 2 ? 8'h55 : 8'h66);
    end
    acc(1, 8'h29, 8'h0C);
    for (n = 8'h2A; n < 8'h2E; n++) acc(1, n[7:0], 8'hFF);
    rd(8'h29, 8'h0C);
    rd(8'h2B, 8'h81);
    avs_byteenable <= 4'hE;
    acc(1, 8'h29, 8'h33);
    avs_byteenable <= 4'hF;
    rd(8'h29, 8'h0C);
    acc(0, 8'h30, 8'h0);
    chk({6'h0, rsp}, 8'h03);
    adc_trigger_cmd <= 1'b1;
    @(posedge clk);
    adc_trigger_cmd <= 1'b0;
    n = 0;
    while (adc_valid !== 1'b1) begin
      @(posedge clk);
      n++;
    end
    chk({7'h0, n >= 399 && n <= 403}, 8'h01);
    rd(8'h2D, 8'h5A);
    give_verdict;
  end
endmodule
